// >>> ptc_edge_detect.sv
// Edge detector with per-pin polarity for the external interrupt pins
`timescale 1ns/1ps
module ptc_edge_detect
  import ptc_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  input  wire logic [EXT_PINS-1:0] pins,
  input  wire logic [EXT_PINS-1:0] rise_sel,
  output logic      [EXT_PINS-1:0] edge_pulse
);
  logic [EXT_PINS-1:0] prev;
  logic                primed;

  // Previous level; primed blocks a false edge right after reset
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      prev   <= '0;
      primed <= 1'b0;
    end else begin
      prev   <= pins;
      primed <= 1'b1;
    end
  end

  // Edges only, never levels; polarity bit picks rising or falling
  always_comb begin
    for (int i = 0; i < EXT_PINS; i++) begin
      edge_pulse[i] = primed & (rise_sel[i] ? (pins[i] & ~prev[i])
                                            : (~pins[i] & prev[i]));
    end
  end
endmodule

// >>> ptc_far_model.sv
// Far-side model: external pins, timer count stepped only by count_from, watched port, core sleep state
`timescale 1ns/1ps
module ptc_far_model (
  input  wire logic        ref_clk,
  output logic      [2:0]  ext_pins,
  output logic      [15:0] basic_timer_count,
  output logic      [7:4]  change_watch_port,
  output logic             power_managed
);
  initial begin
    ext_pins = 3'h0;
    basic_timer_count = 16'h0000;
    change_watch_port = 4'h0;
    power_managed = 1'b0;
  end

  // Load, then count up one per edge; one process owns the count so a load
  // never races an increment. Start values avoid a false FF to 00 step
  task automatic count_from(input logic [15:0] v, input int n);
    @(posedge ref_clk);
    basic_timer_count <= v;
    repeat (n) begin
      @(posedge ref_clk);
      basic_timer_count <= basic_timer_count + 16'h0001;
    end
  endtask

  // Pin edges, port changes and sleep entry, all launched just after an edge
  task automatic drive(input logic [2:0] p, input logic [7:4] q, input logic pm);
    @(posedge ref_clk);
    ext_pins <= p;
    change_watch_port <= q;
    power_managed <= pm;
  endtask
endmodule

// >>> ptc_irq_block.sv
// Pin, timer and port-change interrupt flags with enables and priorities
`timescale 1ns/1ps
module ptc_irq_block
  import ptc_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  input  wire logic [2:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  input  wire logic [EXT_PINS-1:0] ext_pins,
  input  wire logic [15:0]         basic_timer_count,
  input  wire logic [7:4]          change_watch_port,
  input  wire logic                power_managed,
  output logic                     irq_high,
  output logic                     irq_low,
  output logic                     wake_req,
  output logic                     wake_vector,
  output logic      [7:0]          peripheral_irq_en
);
  logic [7:0]          main_irq_control;
  logic [7:0]          second_irq_control;
  logic [7:0]          third_irq_control;
  logic [7:0]          peripheral_irq_enable_two;
  logic [7:0]          config_reg;
  logic [7:0]          next_main;
  logic [7:0]          next_third;
  logic [EXT_PINS-1:0] edge_pulse;
  logic [EXT_PINS-1:0] rise_sel;
  logic [EXT_PINS-1:0] ext_flags;
  logic [EXT_PINS-1:0] ext_ens;
  logic [EXT_PINS-1:0] wake_en;
  logic [15:0]         prev_count;
  logic [7:4]          prev_port;
  logic                watch_primed;
  logic                prev_pm;
  logic                tmr_evt;
  logic                port_evt;
  logic                global_irq_en;
  logic                tmr16;
  logic                src_ext0;
  logic                src_ext1;
  logic                src_ext2;
  logic                src_tmr;
  logic                src_port;
  logic                next_high;
  logic                next_low;
  logic                next_wake;

  function automatic logic wr_hit(input logic [2:0] a, input logic wr,
                                  input logic [2:0] target);
    wr_hit = wr && (a == target);
  endfunction

  assign global_irq_en = main_irq_control[MAIN_GLOBAL_EN];
  assign tmr16         = config_reg[CFG_TMR_16BIT];

  assign rise_sel = {second_irq_control[SEC_EDGE2],
                     second_irq_control[SEC_EDGE1],
                     second_irq_control[SEC_EDGE0]};
  assign ext_flags = {third_irq_control[THR_EXT2_FLAG],
                      third_irq_control[THR_EXT1_FLAG],
                      main_irq_control[MAIN_EXT0_FLAG]};
  assign ext_ens = {third_irq_control[THR_EXT2_EN],
                    third_irq_control[THR_EXT1_EN],
                    main_irq_control[MAIN_EXT0_EN]};

  ptc_edge_detect u_edge (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .pins       (ext_pins),
    .rise_sel   (rise_sel),
    .edge_pulse (edge_pulse)
  );

  // Samples of timer count and watched port for event detection
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      prev_count   <= TMR16_ZERO;
      prev_port    <= '0;
      watch_primed <= 1'b0;
    end else begin
      prev_count   <= basic_timer_count;
      prev_port    <= change_watch_port;
      watch_primed <= 1'b1;
    end
  end

  // Timer rollover; mode bit resets to 8-bit
  always_comb begin
    if (tmr16) begin
      tmr_evt = watch_primed && prev_count == TMR16_TOP
                && basic_timer_count == TMR16_ZERO;
    end else begin
      tmr_evt = watch_primed && prev_count[7:0] == TMR8_TOP
                && basic_timer_count[7:0] == TMR8_ZERO;
    end
  end

  // Any level change on the upper port nibble
  assign port_evt = watch_primed && (prev_port != change_watch_port);

  // Hardware set wins over a software clear in the same cycle
  always_comb begin
    next_main = wr_hit(reg_addr, reg_wr, A_MAIN) ? reg_wdata : main_irq_control;
    next_main[MAIN_TMR_FLAG]  = next_main[MAIN_TMR_FLAG] | tmr_evt;
    next_main[MAIN_PORT_FLAG] = next_main[MAIN_PORT_FLAG] | port_evt;
    next_main[MAIN_EXT0_FLAG] = next_main[MAIN_EXT0_FLAG] | edge_pulse[0];
  end

  always_comb begin
    next_third = wr_hit(reg_addr, reg_wr, A_THIRD)
                 ? (reg_wdata & THIRD_MSK) : third_irq_control;
    next_third[THR_EXT1_FLAG] = next_third[THR_EXT1_FLAG] | edge_pulse[1];
    next_third[THR_EXT2_FLAG] = next_third[THR_EXT2_FLAG] | edge_pulse[2];
  end

  // Flags only drop on a software write; they never self-clear
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      main_irq_control <= MAIN_RST;
    end else begin
      main_irq_control <= next_main;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      third_irq_control <= THIRD_RST;
    end else begin
      third_irq_control <= next_third;
    end
  end

  // Edge polarity and priority bits
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      second_irq_control <= SECOND_RST;
    end else if (wr_hit(reg_addr, reg_wr, A_SECOND)) begin
      second_irq_control <= reg_wdata & SECOND_MSK;
    end
  end

  // Peripheral enables; bit 5 is not stored and reads zero
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      peripheral_irq_enable_two <= PERIPH_RST;
    end else if (wr_hit(reg_addr, reg_wr, A_PERIPH)) begin
      peripheral_irq_enable_two <= reg_wdata & PERIPH_MSK;
    end
  end

  assign peripheral_irq_en = peripheral_irq_enable_two;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      config_reg <= CONFIG_RST;
    end else if (wr_hit(reg_addr, reg_wr, A_CONFIG)) begin
      config_reg <= reg_wdata & CONFIG_MSK;
    end
  end

  // Enables are frozen at entry so late enables cannot wake the core
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      prev_pm <= 1'b0;
      wake_en <= '0;
    end else begin
      prev_pm <= power_managed;
      if (power_managed && !prev_pm) begin
        wake_en <= ext_ens;
      end
    end
  end

  // Requests per source: flag and enable both set
  assign src_ext0 = ext_flags[0] & ext_ens[0];
  assign src_ext1 = ext_flags[1] & ext_ens[1];
  assign src_ext2 = ext_flags[2] & ext_ens[2];
  assign src_tmr  = main_irq_control[MAIN_TMR_FLAG]
                    & main_irq_control[MAIN_TMR_EN];
  assign src_port = main_irq_control[MAIN_PORT_FLAG]
                    & main_irq_control[MAIN_PORT_EN];

  always_comb begin
    next_high = global_irq_en && (src_ext0
      || (src_ext1 && third_irq_control[THR_EXT1_PRIO])
      || (src_ext2 && third_irq_control[THR_EXT2_PRIO])
      || (src_tmr && second_irq_control[SEC_TMR_PRIO])
      || (src_port && second_irq_control[SEC_PORT_PRIO]));
    next_low = global_irq_en && ((src_ext1 && !third_irq_control[THR_EXT1_PRIO])
      || (src_ext2 && !third_irq_control[THR_EXT2_PRIO])
      || (src_tmr && !second_irq_control[SEC_TMR_PRIO])
      || (src_port && !second_irq_control[SEC_PORT_PRIO]));
    next_wake = power_managed && prev_pm && |(ext_flags & wake_en);
  end

  // Registered request outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_high    <= 1'b0;
      irq_low     <= 1'b0;
      wake_req    <= 1'b0;
      wake_vector <= 1'b0;
    end else begin
      irq_high    <= next_high;
      irq_low     <= next_low;
      wake_req    <= next_wake;
      wake_vector <= next_wake && global_irq_en;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        A_MAIN:   reg_rdata <= main_irq_control;
        A_SECOND: reg_rdata <= second_irq_control;
        A_THIRD:  reg_rdata <= third_irq_control;
        A_PERIPH: reg_rdata <= peripheral_irq_enable_two;
        A_CONFIG: reg_rdata <= config_reg;
        A_STATUS: reg_rdata <= {5'h00, wake_req, irq_low, irq_high};
        default:  reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_rd_periph;
    reg_rd && reg_addr == A_PERIPH;
  endsequence

  sequence s_periph_data;
    reg_rdata == peripheral_irq_enable_two && !reg_rdata[5];
  endsequence

  property p_rise_sets;
    edge_pulse[0] |=> main_irq_control[MAIN_EXT0_FLAG];
  endproperty
  a_rise_sets: assert property (p_rise_sets)
    else $error("pin zero edge did not set its flag");

  property p_fall_polarity;
    $past(watch_primed) && $fell(ext_pins[1]) && !second_irq_control[SEC_EDGE1]
      |=> third_irq_control[THR_EXT1_FLAG];
  endproperty
  a_fall_polarity: assert property (p_fall_polarity)
    else $error("falling edge on pin one missed");

  property p_no_enable_no_req;
    !(src_ext0 || src_ext1 || src_ext2 || src_tmr || src_port)
      |=> !irq_high && !irq_low;
  endproperty
  a_no_enable_no_req: assert property (p_no_enable_no_req)
    else $error("request without enabled flag");

  property p_flag_holds;
    main_irq_control[MAIN_EXT0_FLAG] && !reg_wr
      |=> main_irq_control[MAIN_EXT0_FLAG];
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("pin zero flag dropped without software");

  property p_wake;
    power_managed && prev_pm && wake_en[0] && ext_flags[0] |=> wake_req;
  endproperty
  a_wake: assert property (p_wake)
    else $error("enabled pin flag failed to wake");

  property p_vector_gated;
    wake_vector |-> wake_req && $past(global_irq_en);
  endproperty
  a_vector_gated: assert property (p_vector_gated)
    else $error("vector after wake without global enable");

  property p_ext0_high;
    global_irq_en && src_ext0 |=> irq_high;
  endproperty
  a_ext0_high: assert property (p_ext0_high)
    else $error("pin zero not high priority");

  property p_ext1_prio;
    global_irq_en && src_ext1 && !third_irq_control[THR_EXT1_PRIO] |=> irq_low;
  endproperty
  a_ext1_prio: assert property (p_ext1_prio)
    else $error("pin one low priority not routed low");

  property p_tmr8;
    !tmr16 && $past(watch_primed) && $past(basic_timer_count[7:0]) == TMR8_TOP
      && basic_timer_count[7:0] == TMR8_ZERO |=> main_irq_control[MAIN_TMR_FLAG];
  endproperty
  a_tmr8: assert property (p_tmr8)
    else $error("8-bit rollover did not set timer flag");

  property p_port_change;
    $past(watch_primed) && change_watch_port != $past(change_watch_port)
      |=> main_irq_control[MAIN_PORT_FLAG];
  endproperty
  a_port_change: assert property (p_port_change)
    else $error("port change did not set flag");

  property p_tmr16;
    tmr16 && $past(watch_primed) && $past(basic_timer_count) == TMR16_TOP
      && basic_timer_count == TMR16_ZERO |=> main_irq_control[MAIN_TMR_FLAG];
  endproperty
  a_tmr16: assert property (p_tmr16)
    else $error("16-bit rollover did not set timer flag");

  property p_periph_read;
    s_rd_periph |=> s_periph_data;
  endproperty
  a_periph_read: assert property (p_periph_read)
    else $error("enable register two read wrong");
endmodule

// >>> ptc_irq_block_bench.sv
// Self-checking bench for the pin, timer and port-change interrupt block
`timescale 1ns/1ps
module ptc_irq_block_bench
  import ptc_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic [2:0]  ext_pins;
  logic [15:0] basic_timer_count;
  logic [7:4]  change_watch_port;
  logic        power_managed;
  logic        irq_high;
  logic        irq_low;
  logic        wake_req;
  logic        wake_vector;
  logic [7:0]  peripheral_irq_en;
  int          bad_count = 0;
  int          samples_checked = 0;

  always #10 ref_clk = ~ref_clk;

  ptc_far_model far (
    .ref_clk           (ref_clk),
    .ext_pins          (ext_pins),
    .basic_timer_count (basic_timer_count),
    .change_watch_port (change_watch_port),
    .power_managed     (power_managed)
  );

  ptc_irq_block uut (
    .ref_clk           (ref_clk),
    .rst_b             (rst_b),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .ext_pins          (ext_pins),
    .basic_timer_count (basic_timer_count),
    .change_watch_port (change_watch_port),
    .power_managed     (power_managed),
    .irq_high          (irq_high),
    .irq_low           (irq_low),
    .wake_req          (wake_req),
    .wake_vector       (wake_vector),
    .peripheral_irq_en (peripheral_irq_en)
  );

  task automatic wrap_up();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] act, input logic [7:0] exp);
    samples_checked++;
    if (act !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic t_regs();
    rd_chk(A_MAIN, MAIN_RST);
    rd_chk(A_SECOND, SECOND_RST);
    rd_chk(A_THIRD, THIRD_RST);
    rd_chk(A_PERIPH, 8'h00);
    rd_chk(A_CONFIG, CONFIG_RST);
    wr(3'h7, 8'hff);
    rd_chk(3'h7, 8'h00);
    wr(A_PERIPH, 8'hff);
    rd_chk(A_PERIPH, 8'hdf);
    chk(peripheral_irq_en, 8'hdf);
    wr(A_PERIPH, 8'h2a);
    settle(0);
    chk(peripheral_irq_en, 8'h0a);
    wr(A_SECOND, 8'hff);
    rd_chk(A_SECOND, 8'h75);
    wr(A_SECOND, 8'h70);
  endtask

  task automatic t_pins();
    far.drive(3'b001, 4'h0, 1'b0);
    settle(3);
    rd_chk(A_MAIN, 8'h02);
    chk({7'h00, irq_high}, 8'h00);
    far.drive(3'b000, 4'h0, 1'b0);
    wr(A_MAIN, 8'h00);
    rd_chk(A_MAIN, 8'h00);
    wr(A_SECOND, 8'h10);
    far.drive(3'b011, 4'h0, 1'b0);
    settle(3);
    rd_chk(A_MAIN, 8'h00);
    far.drive(3'b000, 4'h0, 1'b0);
    settle(3);
    rd_chk(A_MAIN, 8'h02);
    rd_chk(A_THIRD, 8'h01);
    wr(A_MAIN, 8'h92);
    settle(3);
    chk({6'h00, irq_low, irq_high}, 8'h01);
    settle(6);
    rd_chk(A_MAIN, 8'h92);
    wr(A_MAIN, 8'h90);
    settle(3);
    chk({7'h00, irq_high}, 8'h00);
    wr(A_MAIN, 8'h00);
    wr(A_SECOND, 8'h70);
  endtask

  task automatic t_prio();
    wr(A_MAIN, 8'h80);
    wr(A_THIRD, 8'h98);
    far.drive(3'b010, 4'h0, 1'b0);
    settle(3);
    rd_chk(A_THIRD, 8'h99);
    chk({6'h00, irq_low, irq_high}, 8'h02);
    wr(A_THIRD, 8'h98);
    far.drive(3'b110, 4'h0, 1'b0);
    settle(3);
    rd_chk(A_THIRD, 8'h9a);
    chk({6'h00, irq_low, irq_high}, 8'h01);
    wr(A_THIRD, 8'h5b);
    settle(3);
    chk({6'h00, irq_low, irq_high}, 8'h03);
    wr(A_THIRD, 8'h00);
    wr(A_MAIN, 8'h00);
    far.drive(3'b000, 4'h0, 1'b0);
  endtask

  task automatic t_timer();
    wr(A_MAIN, 8'ha0);
    far.count_from(16'h12fe, 4);
    rd_chk(A_MAIN, 8'ha4);
    chk({6'h00, irq_low, irq_high}, 8'h02);
    wr(A_MAIN, 8'ha0);
    wr(A_SECOND, 8'h74);
    wr(A_CONFIG, 8'h01);
    far.count_from(16'h12fe, 4);
    rd_chk(A_MAIN, 8'ha0);
    far.count_from(16'hfffe, 4);
    rd_chk(A_MAIN, 8'ha4);
    chk({6'h00, irq_low, irq_high}, 8'h01);
    wr(A_CONFIG, 8'h00);
    wr(A_SECOND, 8'h70);
    wr(A_MAIN, 8'h00);
  endtask

  task automatic t_port();
    wr(A_SECOND, 8'h71);
    wr(A_MAIN, 8'h88);
    far.drive(3'b000, 4'h4, 1'b0);
    settle(3);
    rd_chk(A_MAIN, 8'h89);
    chk({6'h00, irq_low, irq_high}, 8'h01);
    wr(A_MAIN, 8'h88);
    rd_chk(A_MAIN, 8'h88);
    far.drive(3'b000, 4'h0, 1'b0);
    settle(3);
    wr(A_SECOND, 8'h70);
    settle(3);
    chk({6'h00, irq_low, irq_high}, 8'h02);
    wr(A_MAIN, 8'h00);
  endtask

  task automatic t_wake();
    wr(A_MAIN, 8'h10);
    far.drive(3'b000, 4'h0, 1'b1);
    settle(3);
    far.drive(3'b001, 4'h0, 1'b1);
    settle(4);
    chk({6'h00, wake_vector, wake_req}, 8'h01);
    wr(A_MAIN, 8'h92);
    settle(3);
    chk({6'h00, wake_vector, wake_req}, 8'h03);
    rd_chk(A_STATUS, 8'h05);
    far.drive(3'b000, 4'h0, 1'b0);
    wr(A_MAIN, 8'h00);
    far.drive(3'b000, 4'h0, 1'b1);
    settle(3);
    wr(A_MAIN, 8'h10);
    far.drive(3'b001, 4'h0, 1'b1);
    settle(4);
    chk({7'h00, wake_req}, 8'h00);
    far.drive(3'b000, 4'h0, 1'b0);
    wr(A_MAIN, 8'h00);
  endtask

  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    settle(2);
    t_regs();
    t_pins();
    t_prio();
    t_timer();
    t_port();
    t_wake();
    wrap_up();
  end
endmodule

// >>> ptc_pkg.sv
// Constants for the pin, timer and port-change interrupt block
package ptc_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] A_MAIN   = 3'h0;
  localparam logic [2:0] A_SECOND = 3'h1;
  localparam logic [2:0] A_THIRD  = 3'h2;
  localparam logic [2:0] A_PERIPH = 3'h3;
  localparam logic [2:0] A_CONFIG = 3'h4;
  localparam logic [2:0] A_STATUS = 3'h5;

  // main_irq_control fields
  localparam int MAIN_GLOBAL_EN = 7;
  localparam int MAIN_TMR_EN    = 5;
  localparam int MAIN_EXT0_EN   = 4;
  localparam int MAIN_PORT_EN   = 3;
  localparam int MAIN_TMR_FLAG  = 2;
  localparam int MAIN_EXT0_FLAG = 1;
  localparam int MAIN_PORT_FLAG = 0;

  // second_irq_control fields
  localparam int SEC_EDGE0     = 6;
  localparam int SEC_EDGE1     = 5;
  localparam int SEC_EDGE2     = 4;
  localparam int SEC_TMR_PRIO  = 2;
  localparam int SEC_PORT_PRIO = 0;

  // third_irq_control fields
  localparam int THR_EXT2_PRIO = 7;
  localparam int THR_EXT1_PRIO = 6;
  localparam int THR_EXT2_EN   = 4;
  localparam int THR_EXT1_EN   = 3;
  localparam int THR_EXT2_FLAG = 1;
  localparam int THR_EXT1_FLAG = 0;

  // Configuration and status fields
  localparam int CFG_TMR_16BIT = 0;
  localparam int STS_IRQ_HIGH  = 0;
  localparam int STS_IRQ_LOW   = 1;
  localparam int STS_WAKE      = 2;

  // Writable masks and reset values
  localparam logic [7:0] MAIN_RST   = 8'h00;
  localparam logic [7:0] SECOND_RST = 8'h70;
  localparam logic [7:0] SECOND_MSK = 8'h75;
  localparam logic [7:0] THIRD_RST  = 8'h00;
  localparam logic [7:0] THIRD_MSK  = 8'hDB;
  localparam logic [7:0] PERIPH_RST = 8'h00;
  localparam logic [7:0] PERIPH_MSK = 8'hDF;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] CONFIG_MSK = 8'h01;

  // Timer rollover patterns
  localparam logic [7:0]  TMR8_TOP   = 8'hFF;
  localparam logic [7:0]  TMR8_ZERO  = 8'h00;
  localparam logic [15:0] TMR16_TOP  = 16'hFFFF;
  localparam logic [15:0] TMR16_ZERO = 16'h0000;

  // Number of external edge pins
  localparam int EXT_PINS = 3;
endpackage
